// file: hw/btit_params.svh
// constants of the burst transmit ingress transcoder
`ifndef BTIT_PARAMS_SVH
`define BTIT_PARAMS_SVH
`define BT_RATE_FILL 72'hFF_0909_0909_0909_09
`define BT_BURST_END 72'hFF_0A0A_0A0A_0A0A_0A0A
`define BT_DELIM 10'h3CA
`define BT_PAYLOAD_BLKS 56
`define BT_PARITY_BLKS 10
`define BT_PARITY_BITS 2560
`define BT_STORE_BITS 2570
`define BT_BLK_BITS 257
`define BT_IQ_DEPTH 8
`define BT_PRE_BLKS 4
`define BT_LATENCY 8
`define BT_FILL_BLK 258'h0
`define BT_END_BLK 258'h0_5555
`define BT_MARK_BLK 258'h0_AAAA
`define BT_SCR_SEED 58'h3FF_FFFF_FFFF_FFFF
`define BT_A_CTRL 8'h00
`define BT_A_STAT 8'h04
`define BT_A_SEL 8'h08
`define BT_A_DATA 8'h0C
`endif

// file: hw/btit_pkg.sv
// types of the burst transmit ingress transcoder
package btit_pkg;
  typedef struct packed {
    logic [7:0] ctl;
    logic [63:0] dat;
  } btit_word_t;
  typedef struct packed {
    logic scr;
    logic [256:0] blk;
  } btit_entry_t;
  typedef enum logic [4:0] {
    FR_IDLE = 5'h01,
    FR_SYNC = 5'h02,
    FR_DATA = 5'h04,
    FR_PAR = 5'h08,
    FR_END = 5'h10
  } btit_state_t;
endpackage : btit_pkg

// file: hw/btit_top.sv
// burst transmit ingress: join, encode, scramble, transcode, frame
// ---------------------------------------------
// Summary of operation
// ---------------------------------------------
`timescale 1ns/1ps
`include "btit_params.svh"
module btit_top (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic LINK_CLK,
  input wire logic [35:0] LINK_D,
  input wire logic [`BT_PARITY_BITS-1:0] PARITY_IN,
  input wire logic PARITY_LOAD,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output btit_pkg::btit_entry_t FEC_BLOCK,
  output logic FEC_VALID,
  output logic [256:0] TX_BLOCK,
  output logic TX_VALID,
  output logic TX_LASER
);
  import btit_pkg::*;
  localparam int EQ_LEN = (`BT_LATENCY - `BT_PRE_BLKS > 2) ?
    `BT_LATENCY - `BT_PRE_BLKS : 2;
  localparam int DIV = `BT_BLK_BITS;

  // ---------------------------------------------
  // encode, scramble and transcode functions
  // ---------------------------------------------
  function automatic logic [7:0] ctl_map(input logic [7:0] c);
    unique case (c)
      8'h07: ctl_map = 8'h00;
      8'h08: ctl_map = 8'h08;
      8'h09: ctl_map = 8'h09;
      8'hFE: ctl_map = 8'h1E;
      default: ctl_map = 8'h80;
    endcase
  endfunction : ctl_map

  // returns {error, payload, header}
  function automatic logic [66:0] encode(input btit_word_t w);
    logic [63:0] p;
    logic [7:0] m;
    logic bad;
    int k;
    logic [7:0] ty [8];
    p = 64'h0;
    bad = 1'b0;
    k = 8;
    ty = '{8'h87, 8'h99, 8'hAA, 8'hB4, 8'hCC, 8'hD2, 8'hE1, 8'hFF};
    for (int i = 7; i >= 0; i--) begin
      if (w.ctl[i] && w.dat[8*i+:8] == 8'hFD) begin
        k = i;
      end
    end
    if (w.ctl == 8'h00) begin
      encode = {1'b0, w.dat, 2'b01};
    end else if (w.ctl == 8'h01 && w.dat[7:0] == 8'hFB) begin
      encode = {1'b0, w.dat[63:8], 8'h78, 2'b10};
    end else begin
      // only 0x1E, 0x78 and the eight terminate types are produced
      if (k < 8 && w.ctl == (8'hFF << k)) begin
        for (int i = 7; i > k; i--) begin
          m = ctl_map(w.dat[8*i+:8]);
          bad = bad | m[7];
          p = (p << 7) | 64'(m[6:0]);
        end
        p = (p << (15 + 7 * k)) | (64'(w.dat) & ~(64'hFFFF_FFFF_FFFF_FFFF
          << (8 * k))) << 8 | 64'(ty[k]);
      end else if (w.ctl == 8'hFF) begin
        for (int i = 7; i >= 0; i--) begin
          m = ctl_map(w.dat[8*i+:8]);
          bad = bad | m[7];
          p = (p << 7) | 64'(m[6:0]);
        end
        p = (p << 8) | 64'h1E;
      end else begin
        bad = 1'b1;
      end
      if (bad) begin
        p = {{8{7'h1E}}, 8'h1E};
      end
      encode = {bad, p, 2'b10};
    end
  endfunction : encode

  // self-synchronising scrambler over the 64 payload bits
  function automatic logic [121:0] scramble(input logic [57:0] s,
                                            input logic [63:0] d);
    logic [63:0] o;
    logic [57:0] st;
    st = s;
    o = 64'h0;
    for (int i = 0; i < 64; i++) begin
      o[i] = d[i] ^ st[38] ^ st[57];
      st = {st[56:0], o[i]};
    end
    scramble = {st, o};
  endfunction : scramble

  function automatic logic [256:0] transcode(input logic [65:0] b [4]);
    logic [247:0] acc;
    logic [3:0] fl;
    logic [3:0] ty;
    int j;
    acc = 248'h0;
    ty = 4'h0;
    j = 4;
    for (int i = 3; i >= 0; i--) begin
      fl[i] = (b[i][1:0] == 2'b01);
      if (!fl[i]) begin
        j = i;
      end
    end
    if (fl == 4'hF) begin
      transcode = {b[3][65:2], b[2][65:2], b[1][65:2], b[0][65:2], 1'b1};
    end else begin
      for (int i = 3; i >= 0; i--) begin
        if (i == j) begin
          acc = {acc[191:0], b[i][65:10]};
          ty = b[i][9:6];
        end else begin
          acc = {acc[183:0], b[i][65:2]};
        end
      end
      transcode = {acc, ty, fl, 1'b0};
    end
  endfunction : transcode

  // ---------------------------------------------
  // link sampling and word join
  // ---------------------------------------------
  logic ck_s1, ck_s2, ck_s3;
  logic [35:0] d_s1, d_s2, hi_q;
  btit_word_t raw_q;
  logic in_tick_q;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ck_s1 <= 1'b0;
      ck_s2 <= 1'b0;
      ck_s3 <= 1'b0;
      d_s1 <= 36'h0;
      d_s2 <= 36'h0;
    end else begin
      ck_s1 <= LINK_CLK;
      ck_s2 <= ck_s1;
      ck_s3 <= ck_s2;
      d_s1 <= LINK_D;
      d_s2 <= d_s1;
    end
  end
  wire ck_rise = ck_s2 & ~ck_s3;
  wire ck_fall = ~ck_s2 & ck_s3;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      hi_q <= 36'h0;
      raw_q <= '0;
      in_tick_q <= 1'b0;
    end else begin
      if (ck_rise) begin
        hi_q <= d_s2;
      end
      // the tick is consumed by the ingress stage in the next cycle
      in_tick_q <= ck_fall;
      if (ck_fall) begin
        raw_q <= {d_s2[35:32], hi_q[35:32], d_s2[31:0], hi_q[31:0]};
      end
    end
  end

  // ---------------------------------------------
  // ingress: drop, encode, scramble, transcode
  // ---------------------------------------------
  logic [65:0] quad_block_store [4];
  logic [2:0] quad_fill_index;
  logic [57:0] scr_q;
  logic enable_q, ovf_q, cerr_q;
  logic [66:0] enc;
  logic [121:0] scr;
  logic accept, push;
  btit_entry_t ingress_word;
  always_comb begin
    enc = encode(raw_q);
    scr = scramble(scr_q, enc[65:2]);
    accept = in_tick_q && enable_q
      && raw_q != `BT_RATE_FILL
      && !(raw_q == `BT_BURST_END
      && quad_fill_index == 3'd0);
    push = accept && quad_fill_index == 3'd3;
    ingress_word.scr = 1'b1;
    ingress_word.blk = transcode('{quad_block_store[0],
      quad_block_store[1], quad_block_store[2],
      {scr[63:0], enc[1:0]}});
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      quad_fill_index <= 3'd0;
      scr_q <= `BT_SCR_SEED;
      FEC_VALID <= 1'b0;
      FEC_BLOCK <= '0;
      for (int i = 0; i < 4; i++) begin
        quad_block_store[i] <= 66'h0;
      end
    end else begin
      FEC_VALID <= push;
      if (accept) begin
        scr_q <= scr[121:64];
        quad_block_store[quad_fill_index[1:0]] <= {scr[63:0], enc[1:0]};
        quad_fill_index <= push ? 3'd0 : quad_fill_index + 3'd1;
      end
      if (push) begin
        FEC_BLOCK <= ingress_word;
      end
    end
  end

  // ---------------------------------------------
  // ingress queue
  // ---------------------------------------------
  btit_entry_t iq_mem [`BT_IQ_DEPTH];
  logic [2:0] iq_wr, iq_rd;
  logic [3:0] iq_cnt;
  logic pop, xfr_tick_q;
  btit_state_t st_q;
  wire iq_empty = iq_cnt == 4'd0;
  wire iq_wen = push && iq_cnt != 4'(`BT_IQ_DEPTH);
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      iq_wr <= 3'd0;
      iq_rd <= 3'd0;
      iq_cnt <= 4'd0;
    end else begin
      if (iq_wen) begin
        iq_mem[iq_wr] <= ingress_word;
        iq_wr <= iq_wr + 3'd1;
      end
      if (pop) begin
        iq_rd <= iq_rd + 3'd1;
      end
      iq_cnt <= iq_cnt + 4'(iq_wen) - 4'(pop);
    end
  end
  a_iq_bound: assert property (@(posedge CLK) disable iff (!RST_N)
    iq_cnt <= 4'(`BT_IQ_DEPTH)) else $error("ingress queue over");
  a_quad_push: assert property (@(posedge CLK) disable iff (!RST_N)
    accept && quad_fill_index == 3'd3 |=> FEC_VALID && FEC_BLOCK.scr
    && quad_fill_index == 3'd0) else $error("group not sent");
  a_fill_drop: assert property (@(posedge CLK) disable iff (!RST_N)
    in_tick_q && raw_q == `BT_RATE_FILL |=> $stable(quad_fill_index))
    else $error("rate fill stored");
  a_in_tick: assert property (@(posedge CLK) disable iff (!RST_N)
    ck_fall |=> in_tick_q ##1 !in_tick_q)
    else $error("input tick wrong");

  // ---------------------------------------------
  // transfer divider and framer
  // ---------------------------------------------
  logic [8:0] div_q;
  logic [256:0] sync_pattern_table [`BT_PRE_BLKS];
  logic [1:0] sync_idx;
  logic [5:0] payload_blocks_remaining;
  logic [3:0] parity_blocks_remaining;
  btit_entry_t frm;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      div_q <= 9'd0;
      xfr_tick_q <= 1'b0;
    end else begin
      div_q <= (div_q == 9'(DIV - 1)) ? 9'd0 : div_q + 9'd1;
      xfr_tick_q <= div_q == 9'(DIV - 1);
    end
  end
  always_comb begin
    pop = 1'b0;
    frm = `BT_FILL_BLK;
    unique case (st_q)
      FR_IDLE: frm = iq_empty ? `BT_FILL_BLK
        : {1'b0, sync_pattern_table[0]};
      FR_SYNC: frm = {1'b0, sync_pattern_table[sync_idx]};
      FR_DATA: begin
        pop = xfr_tick_q && !iq_empty;
        frm = iq_empty ? `BT_MARK_BLK : iq_mem[iq_rd];
      end
      FR_PAR: frm = `BT_MARK_BLK;
      FR_END: frm = `BT_END_BLK;
    endcase
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= FR_IDLE;
      sync_idx <= 2'd0;
      payload_blocks_remaining <= 6'd0;
      parity_blocks_remaining <= 4'd0;
    end else if (xfr_tick_q) begin
      unique case (st_q)
        FR_IDLE: if (!iq_empty) begin
          st_q <= FR_SYNC;
          sync_idx <= 2'd1;
        end
        FR_SYNC: begin
          sync_idx <= sync_idx + 2'd1;
          if (sync_idx == 2'(`BT_PRE_BLKS - 1)) begin
            st_q <= FR_DATA;
            payload_blocks_remaining <= 6'(`BT_PAYLOAD_BLKS);
          end
        end
        FR_DATA: begin
          payload_blocks_remaining <= payload_blocks_remaining - 6'd1;
          if (iq_empty || payload_blocks_remaining == 6'd1) begin
            st_q <= FR_PAR;
            // a marker already went out if the payload was cut short
            parity_blocks_remaining <= iq_empty ?
              4'(`BT_PARITY_BLKS - 1) : 4'(`BT_PARITY_BLKS);
          end
        end
        FR_PAR: begin
          parity_blocks_remaining <= parity_blocks_remaining - 4'd1;
          if (parity_blocks_remaining == 4'd1) begin
            st_q <= iq_empty ? FR_END : FR_DATA;
            payload_blocks_remaining <= 6'(`BT_PAYLOAD_BLKS);
          end
        end
        FR_END: st_q <= FR_IDLE;
      endcase
    end
  end
  a_par_count: assert property (@(posedge CLK) disable iff (!RST_N)
    xfr_tick_q && st_q == FR_PAR && parity_blocks_remaining == 4'd1
    |=> st_q != FR_PAR) else $error("parity run too long");
  a_xfr_gap: assert property (@(posedge CLK) disable iff (!RST_N)
    xfr_tick_q |=> !xfr_tick_q [*8]) else $error("tick too soon");

  // ---------------------------------------------
  // egress delay line, parity store, output
  // ---------------------------------------------
  btit_entry_t eq_q [EQ_LEN];
  logic [`BT_STORE_BITS-1:0] parity_holding_store;
  logic [3:0] slice_q;
  genvar g;
  generate
    for (g = 0; g < EQ_LEN; g++) begin : g_eq
      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          eq_q[g] <= `BT_FILL_BLK;
        end else if (xfr_tick_q) begin
          eq_q[g] <= (g == 0) ? frm : eq_q[(g == 0) ? 0 : g - 1];
        end
      end
    end
  endgenerate
  wire btit_entry_t head = eq_q[EQ_LEN-1];
  wire is_mark = head == `BT_MARK_BLK;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      parity_holding_store <= '0;
      slice_q <= 4'd0;
      TX_BLOCK <= 257'h0;
      TX_VALID <= 1'b0;
      TX_LASER <= 1'b0;
    end else begin
      if (PARITY_LOAD) begin
        parity_holding_store <= {PARITY_IN, `BT_DELIM};
      end
      TX_VALID <= xfr_tick_q;
      if (xfr_tick_q) begin
        if (is_mark) begin
          // parity_slice_fetch: ten slices used as a ring
          TX_BLOCK <= parity_holding_store[257*slice_q+:257];
          slice_q <= (slice_q == 4'd9) ? 4'd0 : slice_q + 4'd1;
        end else begin
          TX_BLOCK <= head.blk;
        end
        if (!TX_LASER && head == {1'b0, sync_pattern_table[0]}) begin
          TX_LASER <= 1'b1;
        end else if (TX_LASER && head == `BT_END_BLK) begin
          TX_LASER <= 1'b0;
        end
      end
    end
  end
  a_slice_wrap: assert property (@(posedge CLK) disable iff (!RST_N)
    xfr_tick_q && is_mark && slice_q == 4'd9 |=> slice_q == 4'd0)
    else $error("slice did not wrap");
  a_end_top: assert property (@(posedge CLK) disable iff (!RST_N)
    xfr_tick_q && st_q inside {FR_END, FR_PAR} |=> !eq_q[0].scr)
    else $error("framer entry marked ingress");

  // ---------------------------------------------
  // AHB-Lite register slave
  // ---------------------------------------------
  logic wr_q;
  logic [7:0] adr_q;
  logic [2:0] sel_ent_q;
  logic [3:0] sel_wrd_q;
  logic [287:0] sync_w;
  wire ap = HSEL && HREADY && HTRANS[1];
  wire wen = wr_q && adr_q == `BT_A_STAT;
  always_comb begin
    sync_w = {31'h0, sync_pattern_table[sel_ent_q[1:0]]};
    sync_w[32*sel_wrd_q+:32] = HWDATA;
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_q <= 1'b0;
      adr_q <= 8'h00;
      HRDATA <= 32'h0;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      enable_q <= 1'b0;
      ovf_q <= 1'b0;
      cerr_q <= 1'b0;
      sel_ent_q <= 3'd0;
      sel_wrd_q <= 4'd0;
      for (int i = 0; i < `BT_PRE_BLKS; i++) begin
        sync_pattern_table[i] <= 257'h0;
      end
    end else begin
      wr_q <= ap && HWRITE;
      adr_q <= HADDR[7:0];
      if (ap && !HWRITE) begin
        unique case (HADDR[7:0])
          `BT_A_CTRL: HRDATA <= {31'h0, enable_q};
          `BT_A_STAT: HRDATA <= {7'h0, TX_LASER, 7'h0, st_q, iq_cnt,
            1'b0, quad_fill_index, 2'h0, cerr_q, ovf_q};
          `BT_A_SEL: HRDATA <= {21'h0, sel_ent_q, 4'h0, sel_wrd_q};
          default: HRDATA <= 32'h0;
        endcase
      end
      if (wr_q && adr_q == `BT_A_CTRL) begin
        enable_q <= HWDATA[0];
      end
      // set wins over a write-one clear in the same cycle
      ovf_q <= (push && !iq_wen) || (ovf_q && !(wen && HWDATA[0]));
      cerr_q <= (accept && enc[66]) || (cerr_q && !(wen && HWDATA[1]));
      if (wr_q && adr_q == `BT_A_SEL) begin
        sel_ent_q <= HWDATA[10:8];
        sel_wrd_q <= HWDATA[3:0];
      end
      if (wr_q && adr_q == `BT_A_DATA && sel_wrd_q < 4'd9
          && sel_ent_q < 3'(`BT_PRE_BLKS)) begin
        sync_pattern_table[sel_ent_q[1:0]] <= sync_w[256:0];
        sel_wrd_q <= sel_wrd_q + 4'd1;
      end
    end
  end
endmodule : btit_top

// file: verif/btit_mac_model.sv
// MAC-side model driving the double-edge 36-bit media interface
`timescale 1ns/1ps
module btit_mac_model (
  output logic LINK_CLK,
  output logic [35:0] LINK_D
);
  // -------------------------------------------
  // idle line
  // -------------------------------------------
  // link clock stands still low between words, as a gated source would
  initial begin
    LINK_CLK = 1'b0;
    LINK_D = 36'h0;
  end
  // -------------------------------------------
  // one word: low half at the rise, high half at the fall
  // -------------------------------------------
  task automatic send_word(input logic [71:0] w);
    LINK_D = {w[67:64], w[31:0]};
    #40 LINK_CLK = 1'b1;
    #40 LINK_D = {w[71:68], w[63:32]};
    #40 LINK_CLK = 1'b0;
    // hold time over: show the inverse so stale data never looks valid
    #40 LINK_D = ~LINK_D;
  endtask : send_word
endmodule : btit_mac_model

// file: verif/tb_burst_tx_ingress_transcoder.sv
// self-checking bench of the burst transmit ingress transcoder
`timescale 1ns/1ps
`include "btit_params.svh"
module tb_burst_tx_ingress_transcoder;
  import btit_pkg::*;
  logic CLK = 1'b0;
  logic RST_N, LINK_CLK, PARITY_LOAD, HSEL, HWRITE, HREADYOUT, HRESP;
  logic FEC_VALID, TX_VALID, TX_LASER, only_data;
  logic [35:0] LINK_D;
  logic [2559:0] PARITY_IN, par;
  logic [2569:0] store;
  logic [31:0] HADDR, HWDATA, HRDATA, rd, d;
  logic [1:0] HTRANS;
  logic [2:0] HSIZE;
  logic [256:0] TX_BLOCK, v, sync0;
  logic [71:0] w;
  btit_entry_t FEC_BLOCK;
  logic [257:0] txq[$];
  logic [256:0] fecq[$];
  int tq[$];
  logic [63:0] dq[$];
  logic [57:0] scr_st;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;
  int fill, n, s, p, e, i, k;
  // end marker value chosen by the designer
  localparam logic [256:0] END_BLK = 257'(`BT_END_BLK);

  always #5 CLK = ~CLK;

  btit_mac_model u_mac (.LINK_CLK(LINK_CLK), .LINK_D(LINK_D));

  btit_top u_dut (
    .CLK(CLK), .RST_N(RST_N), .LINK_CLK(LINK_CLK), .LINK_D(LINK_D),
    .PARITY_IN(PARITY_IN), .PARITY_LOAD(PARITY_LOAD), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
    .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .FEC_BLOCK(FEC_BLOCK),
    .FEC_VALID(FEC_VALID), .TX_BLOCK(TX_BLOCK), .TX_VALID(TX_VALID),
    .TX_LASER(TX_LASER)
  );

  // -------------------------------------------
  // monitors: one-cycle pulses are caught in their own cycle
  // -------------------------------------------
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (FEC_VALID === 1'b1) begin
      fecq.push_back(FEC_BLOCK.blk);
      chk_val("origin bit", 32'h1, {31'h0, FEC_BLOCK.scr});
    end
    if (TX_VALID === 1'b1) begin
      txq.push_back({TX_LASER, TX_BLOCK});
      tq.push_back(cyc);
    end
  end

  // -------------------------------------------
  // checks, bus and link helpers
  // -------------------------------------------
  task automatic chk_val(input string nm, input logic [31:0] x,
                         input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask : chk_val

  task automatic chk_blk(input string nm, input logic [256:0] x,
                         input logic [256:0] g);
    tests_run++;
    if (g !== x) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask : chk_blk

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  task automatic end_test(input string nm);
    $display("test %s done", nm);
  endtask : end_test

  // address phase held until ready, then data phase held until ready
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] r);
    int t;
    t = 0;
    @(posedge CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HADDR <= {24'h0, a};
    HWRITE <= wr;
    do begin
      @(posedge CLK);
      t++;
    end while (HREADYOUT !== 1'b1 && t < 50);
    HSEL <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= wd;
    do begin
      @(posedge CLK);
      t++;
    end while (HREADYOUT !== 1'b1 && t < 100);
    r = HRDATA;
    if (t >= 100) begin
      fails++;
      $display("[ERR] bus ready expected 1 seen timeout");
      finish_test();
    end
  endtask : ahb

  task automatic put(input logic [71:0] x);
    @(posedge CLK);
    #2;
    u_mac.send_word(x);
    repeat (8) @(posedge CLK);
  endtask : put

  task automatic fill_chk(input int x);
    ahb(1'b0, `BT_A_STAT, 32'h0, rd);
    chk_val("quad fill", 32'(x), {29'h0, rd[6:4]});
  endtask : fill_chk

  // how many blocks the quad store holds after word x
  function automatic int next_fill(input logic [71:0] x, input int f);
    if (x == `BT_RATE_FILL) return f;
    if (x == `BT_BURST_END) return (f == 0) ? 0 : f + 1;
    return f + 1;
  endfunction : next_fill

  // reference payload scrambler x58 + x39 + 1, state kept in scr_st
  function automatic logic [63:0] scr_ref(input logic [63:0] x);
    logic [63:0] o;
    for (int b = 0; b < 64; b++) begin
      o[b] = x[b] ^ scr_st[38] ^ scr_st[57];
      scr_st = {scr_st[56:0], o[b]};
    end
    return o;
  endfunction : scr_ref

  // -------------------------------------------
  // main sequence
  // -------------------------------------------
  initial begin
    n = $urandom(21954);
    RST_N = 1'b0;
    PARITY_LOAD = 1'b0;
    PARITY_IN = '0;
    HSEL = 1'b0;
    HADDR = 32'h0;
    HTRANS = 2'b00;
    HWRITE = 1'b0;
    HSIZE = 3'h2;
    HWDATA = 32'h0;
    repeat (3) @(posedge CLK);
    RST_N <= 1'b1;
    chk_val("laser at reset", 32'h0, {31'h0, TX_LASER});
    ahb(1'b0, `BT_A_STAT, 32'h0, rd);
    chk_val("status reset", 32'(FR_IDLE) << 12, rd);
    chk_val("response", 32'h0, {31'h0, HRESP});
    ahb(1'b1, 8'h10, 32'hFFFF_FFFF, rd);
    ahb(1'b0, 8'h10, 32'h0, rd);
    chk_val("unmapped read", 32'h0, rd);
    put({8'h00, $urandom, $urandom});
    fill_chk(0);
    end_test("reset");
    ahb(1'b1, `BT_A_CTRL, 32'h1, rd);
    ahb(1'b0, `BT_A_CTRL, 32'h0, rd);
    chk_val("enable", 32'h1, rd);
    for (e = 0; e < `BT_PRE_BLKS; e++) begin
      ahb(1'b1, `BT_A_SEL, 32'(e) << 8, rd);
      for (k = 0; k < 9; k++) begin
        d = $urandom;
        ahb(1'b1, `BT_A_DATA, d, rd);
        if (k < 8) v[32*k +: 32] = d;
        else v[256] = d[0];
      end
      if (e == 0) sync0 = v;
    end
    for (k = 0; k < 80; k++) par[32*k +: 32] = $urandom;
    store = {par, 10'h3CA};
    @(posedge CLK);
    PARITY_IN <= par;
    PARITY_LOAD <= 1'b1;
    @(posedge CLK);
    PARITY_LOAD <= 1'b0;
    end_test("setup");
    // hand-written corner: a first group of four plain data words
    for (k = 0; k < 4; k++) begin
      w = {8'h00, $urandom, $urandom};
      dq.push_back(w[63:0]);
      put(w);
    end
    fill_chk(0);
    // random mix of data, rate fill and burst end words
    fill = 0;
    only_data = 1'b1;
    for (i = 0; i < 20 && fill < 3; i++) begin
      k = $urandom % 3;
      w = (k == 0) ? {8'h00, $urandom, $urandom} :
          (k == 1) ? `BT_RATE_FILL : `BT_BURST_END;
      if (k == 2 && fill != 0) only_data = 1'b0;
      fill = next_fill(w, fill);
      put(w);
      fill_chk(fill);
    end
    while (fill < 4) begin
      put({8'h00, $urandom, $urandom});
      fill++;
    end
    fill_chk(0);
    for (n = 0; n < 100 && fecq.size() < 2; n++) @(posedge CLK);
    chk_val("groups", 32'h2, 32'(fecq.size()));
    scr_st = `BT_SCR_SEED;
    v = 257'h1;
    for (k = 0; k < 4; k++) begin
      v[64*k+1 +: 64] = scr_ref(dq[k]);
    end
    chk_blk("data group", v, fecq[0]);
    if (only_data) begin
      chk_val("data header", 32'h1, {31'h0, fecq[1][0]});
    end
    end_test("ingress");
    for (n = 0; n < 20000 && TX_LASER !== 1'b1; n++) @(posedge CLK);
    for (; n < 20000 && TX_LASER !== 1'b0; n++) @(posedge CLK);
    repeat (2) @(posedge CLK);
    s = -1;
    e = -1;
    p = -1;
    foreach (txq[j]) begin
      if (s < 0 && txq[j][257] === 1'b1) s = j;
      if (s >= 0 && e < 0 && txq[j][257] === 1'b0) e = j;
      if (s >= 0 && p < 0 && txq[j][256:0] === store[256:0]) p = j;
    end
    if (n >= 20000 || s < 0 || p < 0 || e < 0 || p + 10 > txq.size()) begin
      fails++;
      $display("[ERR] burst shape expected complete seen missing");
      finish_test();
    end
    chk_blk("first sync", sync0, txq[s][256:0]);
    chk_blk("payload", fecq[0], txq[s+`BT_PRE_BLKS][256:0]);
    for (k = 0; k < 10; k++) begin
      chk_blk("parity", store[257*k +: 257], txq[p+k][256:0]);
    end
    chk_val("delimiter", 32'h3CA, {22'h0, txq[p][9:0]});
    chk_val("parity run", 32'(p + 10), 32'(e));
    chk_blk("end marker", END_BLK, txq[e][256:0]);
    k = tq.size();
    chk_val("tick gap", 32'(`BT_BLK_BITS), 32'(tq[k-1] - tq[k-2]));
    end_test("burst");
    finish_test();
  end
endmodule : tb_burst_tx_ingress_transcoder
